// ---- hw/ssq_cfg.svh ----
// Purpose: constants for the servo sequence I/O block
// Assumes: included by every file of the block except the package
// Notes: offsets are byte addresses on a 32-bit classic bus
`ifndef SSQ_CFG_SVH
`define SSQ_CFG_SVH

// ==========================================================================
// terminal counts
`define SSQ_N_IN 8
`define SSQ_N_OUT 4

// ==========================================================================
// function codes (input side)
`define SSQ_FC_EMG 8'h0A
`define SSQ_FC_COAST 8'h36
`define SSQ_FC_SEL0 8'h39
`define SSQ_FC_SEL1 8'h3A
`define SSQ_FC_FCD 8'h52
`define SSQ_FC_DCLR 8'h53
`define SSQ_FC_ACLR 8'h54

// function codes (output side)
`define SSQ_FC_RDY 8'h01
`define SSQ_FC_CRDY 8'h1C

// ==========================================================================
// anti-resonance frequency unit is 0.1 Hz; 300.0 Hz means suppression off
`define SSQ_AR_OFF 16'h0BB8

// ==========================================================================
// register byte offsets
`define SSQ_REG_IN_LO 8'h00
`define SSQ_REG_IN_HI 8'h04
`define SSQ_REG_OUT 8'h08
`define SSQ_REG_CFG 8'h0C
`define SSQ_REG_AR0 8'h10
`define SSQ_REG_AR3 8'h1C
`define SSQ_REG_STAT 8'h20

// reset values
`define SSQ_RST_CODE 8'h00
`define SSQ_RST_AR 32'h0000_0BB8

// field positions
`define SSQ_CFG_FULL 0
`define SSQ_ST_COAST 0
`define SSQ_ST_SEL 1
`define SSQ_ST_SEMI 3
`define SSQ_ST_RDY 4
`define SSQ_ST_CRDY 5
`define SSQ_ST_SUPP 6
`define SSQ_ST_EMG 7

`endif

// ---- hw/ssq_pkg.sv ----
// Purpose: shared types of the servo sequence I/O block
// Assumes: nothing
// Notes: constants live in ssq_cfg.svh
package ssq_pkg;
    // control loop closing point
    typedef enum logic {
        SSQ_LOOP_FULL = 1'b0,
        SSQ_LOOP_SEMI = 1'b1
    } ssq_loop_t;

    // terminal function code
    typedef logic [7:0] ssq_code_t;

    // one anti-resonance set as stored in its register
    typedef struct packed {
        logic [15:0] inertia;
        logic [15:0] freq;
    } ssq_ar_t;
endpackage : ssq_pkg

// ---- hw/ssq_func_if.sv ----
// Purpose: carries terminal codes down and decoded functions back up
// Assumes: ssq_pkg compiled first
// Notes: decoded levels are combinational from synchronised terminals
`timescale 1ns/1ps
`include "ssq_cfg.svh"
interface ssq_func_if;
    import ssq_pkg::*;
    ssq_code_t code [`SSQ_N_IN];
    logic coast;
    logic [1:0] sel;
    logic fcd;
    logic dclr_rise;
    logic aclr;
    logic emergency_stop_input;

    modport dec (input code, output coast, sel, fcd, dclr_rise, aclr, emergency_stop_input);
    modport core (output code, input coast, sel, fcd, dclr_rise, aclr, emergency_stop_input);
endinterface : ssq_func_if

// ---- hw/ssq_term_decode.sv ----
// Purpose: synchronise input terminals and decode their function codes
// Assumes: codes are stable registers of the parent
// Notes: a function on several terminals is the OR of them
`timescale 1ns/1ps
`include "ssq_cfg.svh"
module ssq_term_decode
    import ssq_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // raw terminals
    input wire logic [`SSQ_N_IN-1:0] term_i,
    // decoded functions
    ssq_func_if.dec fn
);
    // ======================================================================
    // synchroniser and edge history
    logic [`SSQ_N_IN-1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic dclr_prev_ff, nxt_dclr_prev;
    logic [`SSQ_N_IN-1:0] m_emg, m_coast, m_sel0, m_sel1, m_fcd, m_dclr, m_aclr;
    logic dclr_lvl;

    // first stage is read only by the second stage
    always_comb begin
        nxt_sync1 = term_i;
        nxt_sync2 = sync1_ff;
        nxt_dclr_prev = dclr_lvl;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            dclr_prev_ff <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            dclr_prev_ff <= nxt_dclr_prev;
        end
    end

    // ======================================================================
    // per-terminal code match
    for (genvar t = 0; t < `SSQ_N_IN; t++) begin : g_match
        assign m_emg[t] = (fn.code[t] == `SSQ_FC_EMG);
        assign m_coast[t] = (fn.code[t] == `SSQ_FC_COAST);
        assign m_sel0[t] = (fn.code[t] == `SSQ_FC_SEL0);
        assign m_sel1[t] = (fn.code[t] == `SSQ_FC_SEL1);
        assign m_fcd[t] = (fn.code[t] == `SSQ_FC_FCD);
        assign m_dclr[t] = (fn.code[t] == `SSQ_FC_DCLR);
        assign m_aclr[t] = (fn.code[t] == `SSQ_FC_ACLR);
    end

    // unassigned functions fall to zero, except the stop input
    assign fn.coast = |(m_coast & sync2_ff);
    assign fn.sel = {|(m_sel1 & sync2_ff), |(m_sel0 & sync2_ff)};
    assign fn.fcd = |(m_fcd & sync2_ff);
    assign fn.aclr = |(m_aclr & sync2_ff);
    assign fn.emergency_stop_input = (|m_emg) ? |(m_emg & sync2_ff) : 1'b1;
    assign dclr_lvl = |(m_dclr & sync2_ff);
    // off-to-on transition only
    assign fn.dclr_rise = dclr_lvl & ~dclr_prev_ff;
endmodule : ssq_term_decode

// ---- hw/ssq_seq_io.sv ----
// Purpose: sequence I/O functions of a servo amplifier with register access
// Assumes: status inputs are synchronous to clk_i
// Notes: classic single-cycle slave, one wait-free ack per request
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`include "ssq_cfg.svh"

// Overview of operation
// - coast request stops motor drive and overrides every other command.
// - coast acts the same in every control state; pulses are not reconciled.
// - code 54 terminal is coast request; unassigned means never asserted.
// - two select bits pick one of four anti-resonance sets.
// - codes 57 and 58 assign select bits 0 and 1; unassigned reads off.
// - with no select assigned, set 0 is always applied.
// - frequency of 300.0 Hz disables suppression for that set.
// - full-closed disable acts only when configured; it falls back to semi-closed.
// - disable change accepted anytime; loop switches only while positioning complete.
// - code 82 assigns full-closed disable; unassigned reads off.
// - rising deviation-clear edge zeroes external-versus-motor deviation, only when full-closed is configured.
// - code 83 assigns deviation clear; unassigned reads off.
// - accumulated-pulse clear zeroes command, feedback and external counters.
// - code 84 assigns accumulated-pulse clear; unassigned reads off.
// - servo-on ready needs stop input on, no fault, control ready, both enables.
// - output terminal with code 1 shows servo-on ready.
// - control ready (code 28) needs stop on, no fault, enables, cpu and mains.
// - edge functions fire on the off-to-on transition.
// - unassigned emergency stop reads as on, meaning not stopped.
module ssq_seq_io
    import ssq_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sequence terminals
    input wire logic [`SSQ_N_IN-1:0] term_i,
    output logic [`SSQ_N_OUT-1:0] out_term_o,
    // amplifier status
    input wire logic fault_flag_i,
    input wire logic safe_enable_a_i,
    input wire logic safe_enable_b_i,
    input wire logic cpu_ok_i,
    input wire logic mains_ok_i,
    input wire logic in_position_i,
    // control outputs
    output logic drive_enable_o,
    output logic [15:0] antires_freq_o,
    output logic [15:0] antires_inertia_o,
    output logic suppress_en_o,
    output logic semi_closed_o,
    output logic dev_clear_o,
    output logic acc_clear_cmd_o,
    output logic acc_clear_fb_o,
    output logic acc_clear_ext_o
);
    // ======================================================================
    // decoder
    ssq_func_if fn_if ();

    ssq_term_decode u_dec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .term_i(term_i),
        .fn(fn_if)
    );

    // ======================================================================
    // register file
    ssq_code_t in_code_ff [`SSQ_N_IN];
    ssq_code_t nxt_in_code [`SSQ_N_IN];
    ssq_code_t out_code_ff [`SSQ_N_OUT];
    ssq_code_t nxt_out_code [`SSQ_N_OUT];
    ssq_ar_t ar_ff [4];
    ssq_ar_t nxt_ar [4];
    logic cfg_full_ff, nxt_cfg_full;
    logic ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    logic [7:0] status;

    assign fn_if.code = in_code_ff;

    // merge byte lanes of a write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = new_w[8*b +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // address decode; one cycle per access, unmapped reads zero
    always_comb begin
        nxt_in_code = in_code_ff;
        nxt_out_code = out_code_ff;
        nxt_ar = ar_ff;
        nxt_cfg_full = cfg_full_ff;
        nxt_ack = 1'b0;
        nxt_rdat = rdat_ff;
        if (wb_cyc_i && wb_stb_i && !ack_ff) begin
            nxt_ack = 1'b1;
            nxt_rdat = 32'h0000_0000;
            if (wb_adr_i == `SSQ_REG_IN_LO) begin
                nxt_rdat = {in_code_ff[3], in_code_ff[2], in_code_ff[1], in_code_ff[0]};
                for (int b = 0; b < 4; b++) begin
                    if (wb_we_i && wb_sel_i[b]) begin
                        nxt_in_code[b] = wb_dat_i[8*b +: 8];
                    end
                end
            end else if (wb_adr_i == `SSQ_REG_IN_HI) begin
                nxt_rdat = {in_code_ff[7], in_code_ff[6], in_code_ff[5], in_code_ff[4]};
                for (int b = 0; b < 4; b++) begin
                    if (wb_we_i && wb_sel_i[b]) begin
                        nxt_in_code[b+4] = wb_dat_i[8*b +: 8];
                    end
                end
            end else if (wb_adr_i == `SSQ_REG_OUT) begin
                nxt_rdat = {out_code_ff[3], out_code_ff[2], out_code_ff[1], out_code_ff[0]};
                for (int b = 0; b < 4; b++) begin
                    if (wb_we_i && wb_sel_i[b]) begin
                        nxt_out_code[b] = wb_dat_i[8*b +: 8];
                    end
                end
            end else if (wb_adr_i == `SSQ_REG_CFG) begin
                nxt_rdat[`SSQ_CFG_FULL] = cfg_full_ff;
                if (wb_we_i && wb_sel_i[0]) begin
                    nxt_cfg_full = wb_dat_i[`SSQ_CFG_FULL];
                end
            end else if (wb_adr_i >= `SSQ_REG_AR0 && wb_adr_i <= `SSQ_REG_AR3
                         && wb_adr_i[1:0] == 2'b00) begin
                nxt_rdat = ar_ff[wb_adr_i[3:2]];
                if (wb_we_i) begin
                    nxt_ar[wb_adr_i[3:2]] = lane_merge(ar_ff[wb_adr_i[3:2]], wb_dat_i,
                                                       wb_sel_i);
                end
            end else if (wb_adr_i == `SSQ_REG_STAT) begin
                nxt_rdat = {24'h00_0000, status};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < `SSQ_N_IN; i++) begin
                in_code_ff[i] <= `SSQ_RST_CODE;
            end
            for (int i = 0; i < `SSQ_N_OUT; i++) begin
                out_code_ff[i] <= `SSQ_RST_CODE;
            end
            for (int i = 0; i < 4; i++) begin
                ar_ff[i] <= `SSQ_RST_AR;
            end
            cfg_full_ff <= 1'b0;
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            in_code_ff <= nxt_in_code;
            out_code_ff <= nxt_out_code;
            ar_ff <= nxt_ar;
            cfg_full_ff <= nxt_cfg_full;
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // ======================================================================
    // function state
    logic coast_ff, nxt_coast;
    logic drive_ff, nxt_drive;
    logic [1:0] sel_ff, nxt_sel;
    ssq_loop_t loop_ff, nxt_loop;
    ssq_loop_t loop_target;
    logic rdy_ff, nxt_rdy;
    logic crdy_ff, nxt_crdy;
    logic dclr_ff, nxt_dclr;
    logic aclr_ff, nxt_aclr;
    logic [15:0] freq_ff, nxt_freq;
    logic [15:0] inertia_ff, nxt_inertia;
    logic supp_ff, nxt_supp;
    logic [`SSQ_N_OUT-1:0] oterm_ff, nxt_oterm;
    ssq_ar_t ar_pick;

    // disable only means something when the full-closed system is configured
    assign loop_target = (cfg_full_ff && !fn_if.fcd) ? SSQ_LOOP_FULL : SSQ_LOOP_SEMI;
    assign ar_pick = ar_ff[fn_if.sel];

    // next values; no control-mode input, so coast is mode-blind by design
    always_comb begin
        nxt_coast = fn_if.coast;
        // drive enable kept in its own flop so the pin has no logic behind it
        nxt_drive = !fn_if.coast;
        nxt_sel = fn_if.sel;
        nxt_freq = ar_pick.freq;
        nxt_inertia = ar_pick.inertia;
        nxt_supp = (ar_pick.freq != `SSQ_AR_OFF);
        nxt_loop = loop_ff;
        // switching mid-move could jolt the axis, so wait for in-position
        if (in_position_i && loop_target != loop_ff) begin
            nxt_loop = loop_target;
        end
        nxt_dclr = fn_if.dclr_rise && cfg_full_ff;
        nxt_aclr = fn_if.aclr;
        nxt_crdy = fn_if.emergency_stop_input && !fault_flag_i && safe_enable_a_i && safe_enable_b_i
                   && cpu_ok_i && mains_ok_i;
        nxt_rdy = fn_if.emergency_stop_input && !fault_flag_i && nxt_crdy
                  && safe_enable_a_i && safe_enable_b_i;
    end

    // output terminal mapping, one lane per terminal
    for (genvar k = 0; k < `SSQ_N_OUT; k++) begin : g_oterm
        assign nxt_oterm[k] = (out_code_ff[k] == `SSQ_FC_RDY) ? nxt_rdy :
                              (out_code_ff[k] == `SSQ_FC_CRDY) ? nxt_crdy : 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coast_ff <= 1'b0;
            drive_ff <= 1'b1;
            sel_ff <= 2'h0;
            loop_ff <= SSQ_LOOP_SEMI;
            rdy_ff <= 1'b0;
            crdy_ff <= 1'b0;
            dclr_ff <= 1'b0;
            aclr_ff <= 1'b0;
            freq_ff <= `SSQ_AR_OFF;
            inertia_ff <= 16'h0000;
            supp_ff <= 1'b0;
            oterm_ff <= '0;
        end else begin
            coast_ff <= nxt_coast;
            drive_ff <= nxt_drive;
            sel_ff <= nxt_sel;
            loop_ff <= nxt_loop;
            rdy_ff <= nxt_rdy;
            crdy_ff <= nxt_crdy;
            dclr_ff <= nxt_dclr;
            aclr_ff <= nxt_aclr;
            freq_ff <= nxt_freq;
            inertia_ff <= nxt_inertia;
            supp_ff <= nxt_supp;
            oterm_ff <= nxt_oterm;
        end
    end

    // ======================================================================
    // outputs and status
    assign drive_enable_o = drive_ff;
    assign antires_freq_o = freq_ff;
    assign antires_inertia_o = inertia_ff;
    assign suppress_en_o = supp_ff;
    assign semi_closed_o = (loop_ff == SSQ_LOOP_SEMI);
    assign dev_clear_o = dclr_ff;
    assign acc_clear_cmd_o = aclr_ff;
    assign acc_clear_fb_o = aclr_ff;
    assign acc_clear_ext_o = aclr_ff;
    assign out_term_o = oterm_ff;

    assign status = {fn_if.emergency_stop_input, supp_ff, crdy_ff, rdy_ff, semi_closed_o, sel_ff, coast_ff};

    // ======================================================================
    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ssq_ar_t ar_pick_q;
    always_ff @(posedge clk_i) begin
        ar_pick_q <= ar_pick;
    end

    AST_COAST_STOP: assert property (fn_if.coast |=> !drive_enable_o)
        else $error("drive still enabled during coast request");
    AST_COAST_FREE: assert property (!fn_if.coast |=> drive_enable_o)
        else $error("drive disabled without coast request");
    AST_SET_PICK: assert property (##1 antires_freq_o == ar_pick_q.freq)
        else $error("applied frequency is not the selected set");
    AST_SUPP_OFF: assert property (suppress_en_o == (antires_freq_o != `SSQ_AR_OFF))
        else $error("suppression enable disagrees with 300.0 Hz marker");
    AST_LOOP_GATE: assert property ($changed(loop_ff) |-> $past(in_position_i))
        else $error("loop switched while positioning incomplete");
    AST_FCD_SEMI: assert property (cfg_full_ff && fn_if.fcd && in_position_i
                                   |=> semi_closed_o)
        else $error("disable request did not reach semi-closed");
    AST_NOCFG_SEMI: assert property (!cfg_full_ff && in_position_i |=> semi_closed_o)
        else $error("full-closed loop without configuration");
    AST_DCLR_PULSE: assert property (dev_clear_o |-> $past(fn_if.dclr_rise) ##1 !dev_clear_o)
        else $error("deviation clear not a single edge pulse");
    AST_ACLR_ALL: assert property (fn_if.aclr |=> acc_clear_cmd_o && acc_clear_fb_o
                                   && acc_clear_ext_o)
        else $error("accumulated counters not all cleared");
    AST_FAULT_DROP: assert property (fault_flag_i |=> !rdy_ff && !crdy_ff)
        else $error("ready shown during fault");
    AST_MAINS_DROP: assert property (!mains_ok_i || !cpu_ok_i |=> !crdy_ff)
        else $error("control ready without mains or healthy cpu");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
endmodule : ssq_seq_io

// ---- verification/ssq_host_model.sv ----
// Purpose: host sequence controller model that drives the input terminals
// Assumes: terminals active high, synchronous to clk_i
// Notes: the deviation clear hold is a count of clock cycles, 2 ms at 20 MHz
`timescale 1ns/1ps
`include "ssq_cfg.svh"
module ssq_host_model #(
    parameter int HOLD_CYC = 40000
) (
    // clock
    input wire logic clk_i,
    // servo-on ready terminal as seen by the host
    input wire logic rdy_i,
    // terminals toward the amplifier
    output logic [`SSQ_N_IN-1:0] term_o
);
    // ==========================================================================
    // terminal driving
    logic moving = 1'b0;
    initial term_o = '0;

    // one terminal to a level just after an edge
    task automatic set_term(input int idx, input logic lvl);
        @(posedge clk_i);
        term_o[idx] <= lvl;
    endtask : set_term

    // the amplifier acts on the edge, but the host still holds the request
    task automatic pulse_hold(input int idx);
        set_term(idx, 1'b1);
        repeat (HOLD_CYC) @(posedge clk_i);
        set_term(idx, 1'b0);
    endtask : pulse_hold

    // select changes are refused while moving, to spare the mechanics a shock
    task automatic set_select(input logic [1:0] s);
        @(posedge clk_i);
        if (!moving) begin
            term_o[2] <= s[0];
            term_o[3] <= s[1];
        end
    endtask : set_select

    // ==========================================================================
    // motion commands: rotation only after ready is seen on
    task automatic rotate(output logic ok);
        ok = (rdy_i === 1'b1);
        moving = ok;
    endtask : rotate

    task automatic stop();
        moving = 1'b0;
    endtask : stop
endmodule : ssq_host_model

// ---- verification/ssq_seq_io_tb_top.sv ----
// Purpose: self-checking bench of the servo sequence I/O block
// Assumes: classic single-cycle slave, terminal functions 3 edges deep
// Notes: terminal map t0 coast, t2/t3 select, t4 disable, t5 dev clear, t6 acc, t7 stop
`timescale 1ns/1ps
`include "ssq_cfg.svh"
module ssq_seq_io_tb_top;
    import ssq_pkg::*;
    // ==========================================================================
    // signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, rq;
    logic wb_ack_o, drv, supp, semi, dclr, acc_c, acc_f, acc_e, ok;
    logic [`SSQ_N_IN-1:0] term;
    logic [`SSQ_N_OUT-1:0] out_term;
    logic fault = 1'b0;
    logic ena = 1'b1;
    logic enb = 1'b1;
    logic cpu = 1'b1;
    logic mains = 1'b1;
    logic inpos = 1'b0;
    logic [15:0] arf, ari;
    int mismatches = 0;
    int n_tests = 0;
    int n_dclr = 0;

    // 50 ns period
    always #25 clk_i = ~clk_i;
    // count dev clear pulses at the sampling edge
    always @(posedge clk_i) if (dclr === 1'b1) n_dclr++;

    ssq_host_model host (.clk_i(clk_i), .rdy_i(out_term[0]), .term_o(term));
    ssq_seq_io DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .term_i(term), .out_term_o(out_term),
        .fault_flag_i(fault), .safe_enable_a_i(ena), .safe_enable_b_i(enb), .cpu_ok_i(cpu),
        .mains_ok_i(mains), .in_position_i(inpos), .drive_enable_o(drv),
        .antires_freq_o(arf), .antires_inertia_o(ari), .suppress_en_o(supp),
        .semi_closed_o(semi), .dev_clear_o(dclr), .acc_clear_cmd_o(acc_c),
        .acc_clear_fb_o(acc_f), .acc_clear_ext_o(acc_e));

    // ==========================================================================
    // shared tasks
    task automatic close_out();
        if (mismatches == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        // wait for the answer however long; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rq = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hF);
    endtask : wr

    // sync chain plus output register, then let the updates land
    task automatic settle();
        repeat (4) @(posedge clk_i);
        #1;
    endtask : settle

    // ==========================================================================
    // scenarios
    task automatic t_reset();
        check("drive", drv, 32'h1);
        check("freq", arf, 32'(`SSQ_AR_OFF));
        check("supp", supp, 32'h0);
        check("semi", semi, 32'h1);
        wb(1'b0, `SSQ_REG_AR0, 32'h0, 4'hF);
        check("ar0", rq, `SSQ_RST_AR);
        wb(1'b0, 8'h40, 32'h0, 4'hF);
        check("unmapped", rq, 32'h0);
    endtask : t_reset

    task automatic t_coast();
        host.set_term(0, 1'b1);
        settle();
        check("drive unassigned", drv, 32'h1);
        wr(`SSQ_REG_IN_LO, 32'h0000_0036);
        settle();
        check("drive coast", drv, 32'h0);
        host.set_term(0, 1'b0);
        repeat (2) @(posedge clk_i);
        #1;
        check("drive sync", drv, 32'h0);
        @(posedge clk_i);
        #1;
        check("drive free", drv, 32'h1);
    endtask : t_coast

    task automatic t_antires();
        logic [15:0] f;
        for (int i = 0; i < 4; i++)
            wr(8'(`SSQ_REG_AR0 + 4 * i), {16'h0200 + 16'(i), (i == 3) ? `SSQ_AR_OFF :
                16'h0100 + 16'(i)});
        host.set_select(2'b11);
        settle();
        check("freq nosel", arf, 32'h0100);
        wb(1'b1, `SSQ_REG_IN_LO, 32'h3A39_FFFF, 4'hC);
        wb(1'b0, `SSQ_REG_IN_LO, 32'h0, 4'hF);
        check("in_lo", rq, 32'h3A39_0036);
        for (int s = 0; s < 4; s++) begin
            host.set_select(2'(s));
            settle();
            f = (s == 3) ? `SSQ_AR_OFF : 16'h0100 + 16'(s);
            check("freq", arf, 32'(f));
            check("inertia", ari, 32'h0200 + 32'(s));
            check("supp", supp, 32'(s != 3));
        end
    endtask : t_antires

    task automatic t_fcd();
        wr(`SSQ_REG_CFG, 32'h1);
        wr(`SSQ_REG_IN_HI, 32'h0000_0052);
        settle();
        check("semi wait", semi, 32'h1);
        @(posedge clk_i) inpos <= 1'b1;
        settle();
        check("full", semi, 32'h0);
        @(posedge clk_i) inpos <= 1'b0;
        host.set_term(4, 1'b1);
        settle();
        check("semi held", semi, 32'h0);
        @(posedge clk_i) inpos <= 1'b1;
        settle();
        check("semi", semi, 32'h1);
        @(posedge clk_i) inpos <= 1'b0;
    endtask : t_fcd

    task automatic t_dclr();
        wr(`SSQ_REG_IN_HI, 32'h0000_5352);
        settle();
        n_dclr = 0;
        host.pulse_hold(5);
        settle();
        check("dclr pulses", 32'(n_dclr), 32'h1);
    endtask : t_dclr

    task automatic t_aclr();
        host.set_term(6, 1'b1);
        settle();
        check("acc unassigned", {acc_c, acc_f, acc_e}, 32'h0);
        wr(`SSQ_REG_IN_HI, 32'h0054_5352);
        settle();
        check("acc", {acc_c, acc_f, acc_e}, 32'h7);
        host.set_term(6, 1'b0);
        settle();
        check("acc off", {acc_c, acc_f, acc_e}, 32'h0);
    endtask : t_aclr

    task automatic t_ready();
        wr(`SSQ_REG_OUT, 32'h0000_1C01);
        settle();
        check("ready", out_term[1:0], 32'h3);
        host.rotate(ok);
        host.stop();
        check("host go", ok, 32'h1);
        for (int k = 0; k < 5; k++) begin
            @(posedge clk_i) {fault, ena, enb, cpu, mains} <= 5'b01111 ^ (5'b10000 >> k);
            settle();
            check("ready bad", out_term[1:0], 32'h0);
        end
        @(posedge clk_i) {fault, ena, enb, cpu, mains} <= 5'b01111;
        wr(`SSQ_REG_IN_HI, 32'h0A54_5352);
        settle();
        check("ready stop", out_term[1:0], 32'h0);
        host.set_term(7, 1'b1);
        settle();
        check("ready run", out_term[1:0], 32'h3);
        check("spare outs", out_term[3:2], 32'h0);
        // stop on, ctrl ready, ready, semi, select 3, no coast, set 3 off
        wb(1'b0, `SSQ_REG_STAT, 32'h0, 4'hF);
        check("stat", rq, 32'h0000_00BE);
    endtask : t_ready

    // ==========================================================================
    // main sequence and watchdog
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        t_reset();
        t_coast();
        t_antires();
        t_fcd();
        t_dclr();
        t_aclr();
        t_ready();
        close_out();
    end

    // the run needs about 40200 cycles, the dev clear hold dominating
    initial begin
        repeat (100000) @(posedge clk_i);
        mismatches++;
        close_out();
    end
endmodule : ssq_seq_io_tb_top
